//--- verilog/fbu_pkg.sv
/*
 * Shared constants and types for the flag, branch and bit operation unit.
 * Assumes a 32-bit Avalon-MM register port with byte addresses.
 */
package fbu_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [5:0] FBU_OFS_CMD = 6'h00;
	localparam logic [5:0] FBU_OFS_STATUS = 6'h04;
	localparam logic [5:0] FBU_OFS_PC = 6'h08;
	localparam logic [5:0] FBU_OFS_OFFSET = 6'h0C;
	localparam logic [5:0] FBU_OFS_RD = 6'h10;
	localparam logic [5:0] FBU_OFS_RR = 6'h14;
	localparam logic [5:0] FBU_OFS_IO_SEL = 6'h18;
	localparam logic [5:0] FBU_OFS_IO_DATA = 6'h1C;
	localparam logic [5:0] FBU_OFS_INFO = 6'h20;

	// ----------------------------------------------------------------
	// Field layout
	// ----------------------------------------------------------------
	localparam int FBU_FLAG_C = 0;
	localparam int FBU_FLAG_Z = 1;
	localparam int FBU_FLAG_N = 2;
	localparam int FBU_FLAG_V = 3;
	localparam int FBU_FLAG_S = 4;
	localparam int FBU_FLAG_H = 5;
	localparam int FBU_FLAG_T = 6;
	localparam int FBU_FLAG_I = 7;
	localparam int FBU_CMD_OP_LSB = 0;
	localparam int FBU_CMD_BIT_LSB = 8;
	localparam int FBU_CMD_IO_LSB = 16;
	localparam int FBU_INFO_TAKEN = 0;
	localparam int FBU_INFO_CYC_LSB = 8;
	localparam int FBU_OFFSET_W = 7;
	localparam int FBU_PC_W_DEF = 16;
	localparam int FBU_IO_DEPTH_DEF = 32;

	// ----------------------------------------------------------------
	// Reset values and cycle counts
	// ----------------------------------------------------------------
	localparam logic [7:0] FBU_STATUS_RST = 8'h00;
	localparam logic [7:0] FBU_BYTE_RST = 8'h00;
	localparam logic [1:0] FBU_CYC_ONE = 2'h1;
	localparam logic [1:0] FBU_CYC_TWO = 2'h2;

	// ----------------------------------------------------------------
	// Operations
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		FBU_BRANCH_NOT_EQUAL = 5'h00,
		FBU_BRANCH_CARRY_SET = 5'h01,
		FBU_BRANCH_CARRY_CLEAR = 5'h02,
		FBU_BRANCH_SAME_OR_HIGHER = 5'h03,
		FBU_BRANCH_LOWER = 5'h04,
		FBU_BRANCH_MINUS = 5'h05,
		FBU_BRANCH_PLUS = 5'h06,
		FBU_BRANCH_SIGNED_GE = 5'h07,
		FBU_BRANCH_SIGNED_LT = 5'h08,
		FBU_BRANCH_HALF_CARRY_SET = 5'h09,
		FBU_BRANCH_OVERFLOW_SET = 5'h0A,
		FBU_BRANCH_OVERFLOW_CLEAR = 5'h0B,
		FBU_BRANCH_IRQ_ENABLED = 5'h0C,
		FBU_BRANCH_IRQ_DISABLED = 5'h0D,
		FBU_SET_IO_BIT = 5'h0E,
		FBU_CLEAR_IO_BIT = 5'h0F,
		FBU_LOGICAL_SHIFT_LEFT = 5'h10,
		FBU_LOGICAL_SHIFT_RIGHT = 5'h11,
		FBU_ROTATE_LEFT_CARRY = 5'h12,
		FBU_ROTATE_RIGHT_CARRY = 5'h13,
		FBU_ARITH_SHIFT_RIGHT = 5'h14,
		FBU_BIT_TO_TRANSFER_FLAG = 5'h15,
		FBU_TRANSFER_FLAG_TO_BIT = 5'h16,
		FBU_SET_OVERFLOW_FLAG = 5'h17,
		FBU_CLEAR_OVERFLOW_FLAG = 5'h18,
		FBU_GLOBAL_IRQ_ON = 5'h19,
		FBU_GLOBAL_IRQ_OFF = 5'h1A,
		FBU_SET_SIGN_FLAG = 5'h1B,
		FBU_CLEAR_SIGN_FLAG = 5'h1C,
		FBU_SET_HALF_CARRY_FLAG = 5'h1D,
		FBU_CLEAR_HALF_CARRY_FLAG = 5'h1E,
		FBU_NO_OP = 5'h1F
	} fbu_op_t;

	typedef enum logic [1:0] {
		FBU_ST_IDLE = 2'b00,
		FBU_ST_EXEC = 2'b01,
		FBU_ST_EXEC2 = 2'b11,
		FBU_ST_READ = 2'b10
	} fbu_state_t;

	typedef struct packed {
		logic [7:0] io_addr;
		logic [2:0] bit_sel;
		fbu_op_t op;
	} fbu_cmd_t;

	typedef struct packed {
		logic [7:0] value;
		logic c;
		logic z;
		logic n;
		logic v;
	} fbu_shift_t;

endpackage : fbu_pkg

//--- verilog/fbu_shift_unit.sv
/*
 * Shift and rotate datapath with its flag results, purely combinational.
 * Assumes the caller only looks at the result for shift or rotate operations.
 */
`timescale 1ns/1ns
`default_nettype none

module fbu_shift_unit (
	input wire fbu_pkg::fbu_op_t op_in,
	input wire logic [7:0] operand_in,
	input wire logic carry_in,
	output fbu_pkg::fbu_shift_t result_out
);
	import fbu_pkg::*;

	logic [7:0] val;
	logic cout;

	always_comb begin
		val = operand_in;
		cout = carry_in;
		case (op_in)
			FBU_LOGICAL_SHIFT_LEFT: begin
				val = {operand_in[6:0], 1'b0};
				cout = operand_in[7];
			end
			FBU_LOGICAL_SHIFT_RIGHT: begin
				val = {1'b0, operand_in[7:1]};
				cout = operand_in[0];
			end
			FBU_ARITH_SHIFT_RIGHT: begin
				val = {operand_in[7], operand_in[7:1]};
				cout = operand_in[0];
			end
			FBU_ROTATE_LEFT_CARRY: begin
				val = {operand_in[6:0], carry_in};
				cout = operand_in[7];
			end
			FBU_ROTATE_RIGHT_CARRY: begin
				val = {carry_in, operand_in[7:1]};
				cout = operand_in[0];
			end
			default: begin
				val = operand_in;
				cout = carry_in;
			end
		endcase
		result_out.value = val;
		result_out.c = cout;
		result_out.z = (val == 8'h00);
		result_out.n = val[7];
		// Overflow follows sign change against the bit shifted out
		result_out.v = val[7] ^ cout;
	end

endmodule : fbu_shift_unit

`default_nettype wire

//--- verilog/fbu_core.sv
/*
 * Flag, branch and bit operation unit: executes one operation per command
 * write, holding the command write in waitrequest for the operation's cycles.
 * Assumes an Avalon-MM master that keeps its request stable until waitrequest
 * is seen low, and a single clock with asynchronous active-high reset.
 */
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none

module fbu_core #(
	parameter int PC_W = fbu_pkg::FBU_PC_W_DEF,
	parameter int IO_DEPTH = fbu_pkg::FBU_IO_DEPTH_DEF
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [5:0] address_in,
	input wire logic read_in,
	input wire logic write_in,
	input wire logic [3:0] byteenable_in,
	input wire logic [31:0] writedata_in,
	output logic [31:0] readdata_out,
	output logic waitrequest_out
);
	import fbu_pkg::*;

	localparam int IO_AW = $clog2(IO_DEPTH);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	fbu_state_t state_r;
	fbu_state_t state_nxt;
	fbu_cmd_t cmd_r;
	logic [7:0] status_r;
	logic [PC_W-1:0] pc_r;
	logic [FBU_OFFSET_W-1:0] offset_r;
	logic [7:0] rd_r;
	logic [7:0] rr_r;
	logic [IO_AW-1:0] io_sel_r;
	logic [7:0] io_mem [IO_DEPTH];
	logic [7:0] io_val_r;
	logic [31:0] readdata_r;
	logic last_taken_r;
	logic [1:0] last_cyc_r;

	logic is_cmd;
	logic idle_write;
	logic branch_op;
	logic io_op;
	logic hit;
	logic two_cycle;
	logic commit1;
	logic commit2;
	logic [PC_W-1:0] pc_seq;
	logic [PC_W-1:0] pc_jump;
	logic [IO_AW-1:0] io_idx;
	logic [31:0] rd_mux;
	fbu_shift_t shift_res;

	function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
			input logic [3:0] be);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction : be_merge

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	assign is_cmd = (address_in == FBU_OFS_CMD);
	assign idle_write = (state_r == FBU_ST_IDLE) && write_in && !is_cmd;
	assign branch_op = (cmd_r.op <= FBU_BRANCH_IRQ_DISABLED);
	assign io_op = (cmd_r.op == FBU_SET_IO_BIT) || (cmd_r.op == FBU_CLEAR_IO_BIT);
	assign io_idx = cmd_r.io_addr[IO_AW-1:0];

	always_comb begin
		case (cmd_r.op)
			FBU_BRANCH_NOT_EQUAL: hit = !status_r[FBU_FLAG_Z];
			FBU_BRANCH_CARRY_SET: hit = status_r[FBU_FLAG_C];
			FBU_BRANCH_LOWER: hit = status_r[FBU_FLAG_C];
			FBU_BRANCH_CARRY_CLEAR: hit = !status_r[FBU_FLAG_C];
			FBU_BRANCH_SAME_OR_HIGHER: hit = !status_r[FBU_FLAG_C];
			FBU_BRANCH_MINUS: hit = status_r[FBU_FLAG_N];
			FBU_BRANCH_PLUS: hit = !status_r[FBU_FLAG_N];
			FBU_BRANCH_SIGNED_GE: hit = !(status_r[FBU_FLAG_N] ^ status_r[FBU_FLAG_V]);
			FBU_BRANCH_SIGNED_LT: hit = status_r[FBU_FLAG_N] ^ status_r[FBU_FLAG_V];
			FBU_BRANCH_HALF_CARRY_SET: hit = status_r[FBU_FLAG_H];
			FBU_BRANCH_OVERFLOW_SET: hit = status_r[FBU_FLAG_V];
			FBU_BRANCH_OVERFLOW_CLEAR: hit = !status_r[FBU_FLAG_V];
			FBU_BRANCH_IRQ_ENABLED: hit = status_r[FBU_FLAG_I];
			FBU_BRANCH_IRQ_DISABLED: hit = !status_r[FBU_FLAG_I];
			default: hit = 1'b0;
		endcase
	end

	// Taken branches and I/O bit writes need a second cycle
	assign two_cycle = (branch_op && hit) || io_op;
	assign commit1 = (state_r == FBU_ST_EXEC) && !two_cycle;
	assign commit2 = (state_r == FBU_ST_EXEC2);

	assign pc_seq = PC_W'(pc_r + 1'b1);
	// Offset is sign-extended so backward branches wrap correctly
	assign pc_jump = PC_W'(pc_r + {{(PC_W-FBU_OFFSET_W){offset_r[FBU_OFFSET_W-1]}}, offset_r} + 1'b1);

	fbu_shift_unit u_shift (
		.op_in(cmd_r.op),
		.operand_in(rd_r),
		.carry_in(status_r[FBU_FLAG_C]),
		.result_out(shift_res)
	);

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------
	always_comb begin
		case (state_r)
			FBU_ST_IDLE: begin
				waitrequest_out = read_in || (write_in && is_cmd);
				if (write_in && is_cmd) begin
					state_nxt = FBU_ST_EXEC;
				end else if (read_in) begin
					state_nxt = FBU_ST_READ;
				end else begin
					state_nxt = FBU_ST_IDLE;
				end
			end
			FBU_ST_EXEC: begin
				waitrequest_out = two_cycle;
				state_nxt = two_cycle ? FBU_ST_EXEC2 : FBU_ST_IDLE;
			end
			FBU_ST_EXEC2: begin
				waitrequest_out = 1'b0;
				state_nxt = FBU_ST_IDLE;
			end
			FBU_ST_READ: begin
				waitrequest_out = 1'b0;
				state_nxt = FBU_ST_IDLE;
			end
			default: begin
				waitrequest_out = 1'b0;
				state_nxt = FBU_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_r <= FBU_ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			cmd_r <= '{io_addr: FBU_BYTE_RST, bit_sel: 3'h0, op: FBU_NO_OP};
		end else if (state_r == FBU_ST_IDLE && write_in && is_cmd) begin
			cmd_r.op <= fbu_op_t'(writedata_in[FBU_CMD_OP_LSB +: 5]);
			cmd_r.bit_sel <= writedata_in[FBU_CMD_BIT_LSB +: 3];
			cmd_r.io_addr <= writedata_in[FBU_CMD_IO_LSB +: 8];
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_comb begin
		case (address_in)
			FBU_OFS_CMD: rd_mux = {8'h00, cmd_r.io_addr, 5'h00, cmd_r.bit_sel, 3'h0, cmd_r.op};
			FBU_OFS_STATUS: rd_mux = {24'h000000, status_r};
			FBU_OFS_PC: rd_mux = 32'(pc_r);
			FBU_OFS_OFFSET: rd_mux = {25'h0000000, offset_r};
			FBU_OFS_RD: rd_mux = {24'h000000, rd_r};
			FBU_OFS_RR: rd_mux = {24'h000000, rr_r};
			FBU_OFS_IO_SEL: rd_mux = 32'(io_sel_r);
			FBU_OFS_IO_DATA: rd_mux = {24'h000000, io_mem[io_sel_r]};
			FBU_OFS_INFO: rd_mux = {22'h000000, last_cyc_r, 7'h00, last_taken_r};
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			readdata_r <= 32'h00000000;
		end else if (state_r == FBU_ST_IDLE && read_in && !write_in) begin
			readdata_r <= rd_mux;
		end
	end

	assign readdata_out = readdata_r;

	// ----------------------------------------------------------------
	// Program counter
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			pc_r <= '0;
		end else if (commit2 && branch_op) begin
			pc_r <= pc_jump;
		end else if (commit1 || commit2) begin
			pc_r <= pc_seq;
		end else if (idle_write && address_in == FBU_OFS_PC) begin
			pc_r <= PC_W'(be_merge(32'(pc_r), writedata_in, byteenable_in));
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			last_taken_r <= 1'b0;
			last_cyc_r <= 2'h0;
		end else if (commit1) begin
			last_taken_r <= 1'b0;
			last_cyc_r <= FBU_CYC_ONE;
		end else if (commit2) begin
			last_taken_r <= branch_op;
			last_cyc_r <= FBU_CYC_TWO;
		end
	end

	// ----------------------------------------------------------------
	// Status flags
	// ----------------------------------------------------------------
	// Untaken branches fall to the default case here; taken branches and I/O bit writes never reach this process
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			status_r <= FBU_STATUS_RST;
		end else if (commit1) begin
			case (cmd_r.op)
				FBU_LOGICAL_SHIFT_LEFT, FBU_LOGICAL_SHIFT_RIGHT, FBU_ARITH_SHIFT_RIGHT,
				FBU_ROTATE_LEFT_CARRY, FBU_ROTATE_RIGHT_CARRY: begin
					status_r[FBU_FLAG_C] <= shift_res.c;
					status_r[FBU_FLAG_Z] <= shift_res.z;
					status_r[FBU_FLAG_N] <= shift_res.n;
					status_r[FBU_FLAG_V] <= shift_res.v;
				end
				FBU_BIT_TO_TRANSFER_FLAG: status_r[FBU_FLAG_T] <= rr_r[cmd_r.bit_sel];
				FBU_SET_OVERFLOW_FLAG: status_r[FBU_FLAG_V] <= 1'b1;
				FBU_CLEAR_OVERFLOW_FLAG: status_r[FBU_FLAG_V] <= 1'b0;
				FBU_GLOBAL_IRQ_ON: status_r[FBU_FLAG_I] <= 1'b1;
				FBU_GLOBAL_IRQ_OFF: status_r[FBU_FLAG_I] <= 1'b0;
				FBU_SET_SIGN_FLAG: status_r[FBU_FLAG_S] <= 1'b1;
				FBU_CLEAR_SIGN_FLAG: status_r[FBU_FLAG_S] <= 1'b0;
				FBU_SET_HALF_CARRY_FLAG: status_r[FBU_FLAG_H] <= 1'b1;
				FBU_CLEAR_HALF_CARRY_FLAG: status_r[FBU_FLAG_H] <= 1'b0;
				default: status_r <= status_r;
			endcase
		end else if (idle_write && address_in == FBU_OFS_STATUS && byteenable_in[0]) begin
			status_r <= writedata_in[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Working registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rd_r <= FBU_BYTE_RST;
		end else if (commit1 && cmd_r.op >= FBU_LOGICAL_SHIFT_LEFT && cmd_r.op <= FBU_ARITH_SHIFT_RIGHT) begin
			rd_r <= shift_res.value;
		end else if (commit1 && cmd_r.op == FBU_TRANSFER_FLAG_TO_BIT) begin
			rd_r[cmd_r.bit_sel] <= status_r[FBU_FLAG_T];
		end else if (idle_write && address_in == FBU_OFS_RD && byteenable_in[0]) begin
			rd_r <= writedata_in[7:0];
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rr_r <= FBU_BYTE_RST;
			offset_r <= '0;
			io_sel_r <= '0;
		end else if (idle_write && byteenable_in[0]) begin
			if (address_in == FBU_OFS_RR) begin
				rr_r <= writedata_in[7:0];
			end
			if (address_in == FBU_OFS_OFFSET) begin
				offset_r <= writedata_in[FBU_OFFSET_W-1:0];
			end
			if (address_in == FBU_OFS_IO_SEL) begin
				io_sel_r <= writedata_in[IO_AW-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// I/O register space
	// ----------------------------------------------------------------
	// Read in the first cycle, write back in the second: other bits survive
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			io_val_r <= FBU_BYTE_RST;
		end else if (state_r == FBU_ST_EXEC && io_op) begin
			io_val_r <= io_mem[io_idx];
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			for (int i = 0; i < IO_DEPTH; i++) begin
				io_mem[i] <= FBU_BYTE_RST;
			end
		end else if (commit2 && cmd_r.op == FBU_SET_IO_BIT) begin
			io_mem[io_idx] <= io_val_r | (8'h01 << cmd_r.bit_sel);
		end else if (commit2 && cmd_r.op == FBU_CLEAR_IO_BIT) begin
			io_mem[io_idx] <= io_val_r & ~(8'h01 << cmd_r.bit_sel);
		end else if (idle_write && address_in == FBU_OFS_IO_DATA && byteenable_in[0]) begin
			io_mem[io_sel_r] <= writedata_in[7:0];
		end
	end

endmodule : fbu_core

`default_nettype wire

//--- bench/fbu_core_props.sv
/*
 * Cycle-count checker for command writes to fbu_core.
 * Assumes one command per write request, with write low between requests.
 */
`timescale 1ns/1ns
`default_nettype none
module fbu_core_props
	import fbu_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [5:0] address_in,
	input wire logic write_in,
	input wire logic [31:0] writedata_in,
	input wire logic waitrequest_out
);
	logic wr_r;
	logic go;
	logic w;
	logic [4:0] op;
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in)
			wr_r <= 1'b0;
		else
			wr_r <= write_in;
	end
	// First cycle only, a held write is not a new command
	assign go = write_in && !wr_r && address_in == FBU_OFS_CMD;
	assign op = writedata_in[4:0];
	assign w = waitrequest_out;
	AST_IO_SET: assert property (go && op == FBU_SET_IO_BIT |-> w [*2] ##1 !w)
		else $error("io set length wrong");
	AST_IO_CLR: assert property (go && op == FBU_CLEAR_IO_BIT |-> w [*2] ##1 !w)
		else $error("io clear length wrong");
	AST_SHIFT: assert property (go && op inside {5'h10, 5'h11, 5'h14} |-> w ##1 !w)
		else $error("shift length wrong");
	AST_ROT: assert property (go && op inside {5'h12, 5'h13} |-> w ##1 !w)
		else $error("rotate length wrong");
	AST_TBIT: assert property (go && op inside {5'h15, 5'h16} |-> w ##1 !w)
		else $error("bit transfer length wrong");
	AST_VI: assert property (go && op inside {[5'h17:5'h1A]} |-> w ##1 !w)
		else $error("flag op length wrong");
	AST_SH: assert property (go && op inside {[5'h1B:5'h1E]} |-> w ##1 !w)
		else $error("flag op length wrong");
	AST_BRANCH: assert property (go && op < 5'h0E |-> w ##1 (!w or (w ##1 !w)))
		else $error("branch length wrong");
endmodule : fbu_core_props
bind fbu_core fbu_core_props fbu_core_props_i (.clk_in(clk_in), .reset_in(reset_in), .address_in(address_in),
	.write_in(write_in), .writedata_in(writedata_in), .waitrequest_out(waitrequest_out));
`default_nettype wire

//--- bench/fbu_host_model.sv
/*
 * Host model: the software side driving the register port.
 * Assumes one task call at a time; timeouts are counted for the bench.
 */
`timescale 1ns/1ns
`default_nettype none
module fbu_host_model (
	input wire logic clk_in,
	input wire logic [31:0] readdata_in,
	input wire logic waitrequest_in,
	output logic [5:0] address_out,
	output logic read_out,
	output logic write_out,
	output logic [3:0] byteenable_out,
	output logic [31:0] writedata_out
);
	int tmo_count = 0;
	initial begin
		address_out = 6'h00;
		read_out = 1'b0;
		write_out = 1'b0;
		byteenable_out = 4'hF;
		writedata_out = 32'h0;
	end
	// Samples at the rising edge itself, before that edge's updates land
	task automatic xfer(input logic rd, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q,
			input logic [3:0] be = 4'hF);
		logic w;
		int i;
		@(posedge clk_in);
		address_out <= a;
		writedata_out <= d;
		byteenable_out <= be;
		read_out <= rd;
		write_out <= !rd;
		w = 1'b1;
		q = 32'h0;
		for (i = 0; i < 64 && w; i++) begin
			@(posedge clk_in);
			w = waitrequest_in;
			q = readdata_in;
		end
		if (w)
			tmo_count++;
		read_out <= 1'b0;
		write_out <= 1'b0;
		writedata_out <= ~d;
	endtask : xfer
endmodule : fbu_host_model
`default_nettype wire

//--- bench/fbu_core_bench.sv
/*
 * Self-checking bench: every operation except FBU_NO_OP through the register port.
 * Assumes the host model and the bound checker are compiled with it.
 */
`timescale 1ns/1ns
`default_nettype none
module fbu_core_bench;
	import fbu_pkg::*;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	wire logic [5:0] address_in;
	wire logic read_in;
	wire logic write_in;
	wire logic [3:0] byteenable_in;
	wire logic [31:0] writedata_in;
	wire logic [31:0] readdata_out;
	wire logic waitrequest_out;
	int n_fail = 0;
	int compares = 0;
	int o, c, b, j;
	int fb[4] = '{3, 7, 4, 5};
	logic [7:0] sv[4] = '{8'h00, 8'h35, 8'hCA, 8'hFF};
	logic [6:0] kv[4] = '{7'h05, 7'h40, 7'h3F, 7'h7F};
	logic [31:0] rdv;
	logic [7:0] s, es, r, p;
	logic [7:0] pat = 8'h5A;
	logic cr, t;
	logic [15:0] pe;
	fbu_core fbu_core_i (.clk_in(clk_in), .reset_in(reset_in), .address_in(address_in), .read_in(read_in),
		.write_in(write_in), .byteenable_in(byteenable_in), .writedata_in(writedata_in),
		.readdata_out(readdata_out), .waitrequest_out(waitrequest_out));
	fbu_host_model fbu_host_model_i (.clk_in(clk_in), .readdata_in(readdata_out), .waitrequest_in(waitrequest_out),
		.address_out(address_in), .read_out(read_in), .write_out(write_in), .byteenable_out(byteenable_in),
		.writedata_out(writedata_in));
	initial begin
		forever #2 clk_in = ~clk_in;
	end
	task automatic end_of_test;
		n_fail += fbu_host_model_i.tmo_count;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		fbu_host_model_i.xfer(1'b0, a, d, rdv);
		if (fbu_host_model_i.tmo_count > 0)
			end_of_test();
	endtask : wr
	task automatic rc(input logic [5:0] a, input logic [31:0] e);
		fbu_host_model_i.xfer(1'b1, a, 32'h0, rdv);
		if (fbu_host_model_i.tmo_count > 0)
			end_of_test();
		compares++;
		if (rdv !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, rdv, e);
		end
	endtask : rc
	task automatic op(input logic [4:0] x, input logic [2:0] bs, input logic [7:0] io);
		wr(FBU_OFS_CMD, {8'h00, io, 5'h00, bs, 3'h0, x});
	endtask : op
	function automatic logic tk(input logic [4:0] x, input logic [7:0] f);
		case (x)
			5'h00: return !f[1];
			5'h01, 5'h04: return f[0];
			5'h02, 5'h03: return !f[0];
			5'h05: return f[2];
			5'h06: return !f[2];
			5'h07: return !(f[2] ^ f[3]);
			5'h08: return f[2] ^ f[3];
			5'h09: return f[5];
			5'h0A: return f[3];
			5'h0B: return !f[3];
			5'h0C: return f[7];
			default: return !f[7];
		endcase
	endfunction : tk
	// Hang guard, well above the longest run
	initial begin
		repeat (20000) @(posedge clk_in);
		n_fail++;
		end_of_test();
	end
	initial begin
		repeat (16) @(posedge clk_in);
		reset_in <= 1'b0;
		rc(FBU_OFS_STATUS, 32'h0);
		rc(FBU_OFS_PC, 32'h0);
		rc(6'h24, 32'h0);
		// The four flag patterns flip every condition at least once
		for (j = 0; j < 4; j++) for (o = 0; o < 14; o++) begin
			wr(FBU_OFS_STATUS, {24'h0, sv[j]});
			wr(FBU_OFS_PC, 32'h100);
			wr(FBU_OFS_OFFSET, {25'h0, kv[j]});
			op(o[4:0], 3'h0, 8'h00);
			t = tk(o[4:0], sv[j]);
			pe = 16'h0101 + {{9{kv[j][6]}}, kv[j]};
			rc(FBU_OFS_PC, {16'h0, t ? pe : 16'h0101});
			rc(FBU_OFS_STATUS, {24'h0, sv[j]});
			rc(FBU_OFS_INFO, {22'h0, t ? 2'h2 : 2'h1, 7'h0, t});
		end
		// Operand 00 included so a zero result sets Z
		for (j = 0; j < 4; j++) for (o = 16; o < 21; o++) for (c = 0; c < 2; c++) begin
			s = 8'hAE | c[7:0];
			case (o)
				16: {cr, r} = {sv[j], 1'b0};
				17: {r, cr} = {1'b0, sv[j]};
				18: {cr, r} = {sv[j], c[0]};
				19: {r, cr} = {c[0], sv[j]};
				default: {r, cr} = {sv[j][7], sv[j]};
			endcase
			es = {s[7:4], r[7] ^ cr, r[7], r == 8'h00, cr};
			wr(FBU_OFS_STATUS, {24'h0, s});
			wr(FBU_OFS_RD, {24'h0, sv[j]});
			op(o[4:0], 3'h0, 8'h00);
			rc(FBU_OFS_RD, {24'h0, r});
			rc(FBU_OFS_STATUS, {24'h0, es});
		end
		for (b = 0; b < 8; b++) begin
			wr(FBU_OFS_RR, {24'h0, pat});
			wr(FBU_OFS_STATUS, 32'hBF);
			op(FBU_BIT_TO_TRANSFER_FLAG, b[2:0], 8'h00);
			es = 8'hBF | {1'b0, pat[b], 6'h00};
			rc(FBU_OFS_STATUS, {24'h0, es});
			wr(FBU_OFS_RD, 32'hC3);
			op(FBU_TRANSFER_FLAG_TO_BIT, b[2:0], 8'h00);
			r = 8'hC3;
			r[b] = pat[b];
			rc(FBU_OFS_RD, {24'h0, r});
			rc(FBU_OFS_STATUS, {24'h0, es});
			p = 8'(b * 3 + 1);
			r = pat;
			r[b] = 1'b1;
			wr(FBU_OFS_IO_SEL, {24'h0, p});
			wr(FBU_OFS_IO_DATA, {24'h0, pat});
			wr(FBU_OFS_STATUS, 32'h55);
			op(FBU_SET_IO_BIT, b[2:0], p);
			rc(FBU_OFS_IO_DATA, {24'h0, r});
			r[b] = 1'b0;
			op(FBU_CLEAR_IO_BIT, b[2:0], p);
			rc(FBU_OFS_IO_DATA, {24'h0, r});
			rc(FBU_OFS_STATUS, 32'h55);
		end
		for (o = 23; o < 31; o++) for (c = 0; c < 2; c++) begin
			s = c ? 8'hFF : 8'h00;
			es = s;
			es[fb[(o - 23) / 2]] = o[0];
			wr(FBU_OFS_STATUS, {24'h0, s});
			op(o[4:0], 3'h0, 8'h00);
			rc(FBU_OFS_STATUS, {24'h0, es});
		end
		// Second reset in mid-run clears the flags again
		reset_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		reset_in <= 1'b0;
		rc(FBU_OFS_STATUS, 32'h0);
		rc(FBU_OFS_PC, 32'h0);
		// Lane 0 off: an 8-bit register must ignore the write
		fbu_host_model_i.xfer(1'b0, FBU_OFS_STATUS, 32'hFF, rdv, 4'hE);
		rc(FBU_OFS_STATUS, 32'h0);
		end_of_test();
	end
endmodule : fbu_core_bench
`default_nettype wire
